// ==== inc/chg_params.svh ====
// Purpose: constants of the charger enable and gate drive block
// Assumes: 20 MHz system clock
// Notes: cycle counts follow from the times below at the system clock rate
`ifndef CHG_PARAMS_SVH
`define CHG_PARAMS_SVH

`define CHG_CLK_HZ 20000000
`define CHG_SETTLE_MS 500
`define CHG_SETTLE_CYC (`CHG_SETTLE_MS * (`CHG_CLK_HZ / 1000))
`define CHG_SETTLE_W 24
`define CHG_PULSE_NS 80
`define CHG_PULSE_CYC ((`CHG_PULSE_NS * (`CHG_CLK_HZ / 1000000) + 999) / 1000)
`define CHG_DEAD_NS 50
`define CHG_DEAD_CYC ((`CHG_DEAD_NS * (`CHG_CLK_HZ / 1000000) + 999) / 1000)
`define CHG_PH_W 4
`define CHG_FSW_LO_KHZ 300
`define CHG_FSW_HI_KHZ 500
`define CHG_PER_LO (`CHG_CLK_HZ / (`CHG_FSW_LO_KHZ * 1000))
`define CHG_PER_HI (`CHG_CLK_HZ / (`CHG_FSW_HI_KHZ * 1000))
`define CHG_PER_W 7
`define CHG_BOOTSTRAP_NODE_CYC 3'h3
`define CHG_SYNC_N 11
`define CHG_MODE_ADDR 8'h12
`define CHG_STAT_ADDR 8'h13
`define CHG_MODE_RST 16'h0001
`define CHG_STOP_BIT 0
`define CHG_FS_BIT 5
`define CHG_UNRDY_BIT 0
`define CHG_OFF_BIT 1

`endif

// ==== inc/chg_pkg.sv ====
// Purpose: types of the charger enable and gate drive block
// Assumes: constants come from chg_params.svh
// Notes: one-hot gate sequencer states
`include "chg_params.svh"

package chg_pkg;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_HS = 5'h02,
        ST_DT1 = 5'h04,
        ST_LS = 5'h08,
        ST_DT2 = 5'h10
    } chg_fsm_e;

    typedef logic [15:0] chg_word_t;

    typedef struct packed {
        chg_word_t mode;
        chg_word_t rdata;
        logic unready;
        logic off;
        logic en;
        logic bypass;
        logic [`CHG_PER_W-1:0] per;
        chg_fsm_e fsm;
        logic pulse;
        logic [2:0] bootstrap_node_cnt;
        logic hs;
        logic ls;
    } chg_state_s;

endpackage

// ==== hw/chg_sync.sv ====
// Purpose: two-stage synchroniser for a group of pin levels
// Assumes: inputs are asynchronous levels
// Notes: first stage feeds only the second stage
`timescale 1ns/100ps
`default_nettype none

module chg_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } chg_sync_s;

    chg_sync_s st;
    chg_sync_s nxt;

    always_comb
    begin
        nxt.s1 = d_i;
        nxt.s2 = st.s1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            st <= '0;
        else
            st <= nxt;
    end

    assign q_o = st.s2;

endmodule // chg_sync

`default_nettype wire

// ==== hw/chg_timer.sv ====
// Purpose: loadable down counter with terminal flag
// Assumes: load value is the wanted cycle count minus one
// Notes: done_o is high while the count rests at zero
`timescale 1ns/100ps
`default_nettype none

module chg_timer #(
    parameter int CW = 4
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic load_i,
    input wire logic [CW-1:0] load_val_i,
    output logic done_o
);

    typedef struct packed {
        logic [CW-1:0] cnt;
    } chg_tmr_s;

    chg_tmr_s st;
    chg_tmr_s nxt;

    always_comb
    begin
        nxt = st;
        if (load_i)
            nxt.cnt = load_val_i;
        else if (st.cnt != '0)
            nxt.cnt = st.cnt - 1'b1;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            st <= '0;
        else
            st <= nxt;
    end

    assign done_o = (st.cnt == '0);

endmodule // chg_timer

`default_nettype wire

// ==== hw/chg_ctrl.sv ====
// Purpose: charge enable qualification and gate drive sequencing
// Assumes: comparator inputs are asynchronous levels
// Notes: register port is a plain internal write/read strobe set
`timescale 1ns/100ps
`default_nettype none
`include "chg_params.svh"

module chg_ctrl
    import chg_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = `CHG_SETTLE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    output logic [15:0] reg_rdata_o,
    input wire logic adapter_detect_input_i,
    input wire logic gate_drive_ldo_ok_i,
    input wire logic aux_5v_ldo_ok_i,
    input wire logic charge_permit_pin_n_i,
    input wire logic thermal_shutdown_limit_i,
    input wire logic overcurrent_i,
    input wire logic thermistor_sense_ok_i,
    input wire logic bootstrap_low_i,
    input wire logic sync_threshold_above_i,
    input wire logic adapter_near_pack_i,
    input wire logic error_amp_above_ramp_i,
    output logic hs_gate_o,
    output logic ls_gate_o,
    output logic bypass_on_o,
    output logic charge_unready_flag_o,
    output logic charger_off_o,
    output logic charge_enable_o
);

    localparam chg_state_s ST_RST = '{
        mode: `CHG_MODE_RST,
        fsm: ST_OFF,
        unready: 1'b1,
        off: 1'b1,
        default: '0
    };

    chg_state_s st;
    chg_state_s nxt;

    logic [`CHG_SYNC_N-1:0] sync_q;
    logic det_s;
    logic ldo_s;
    logic aux_s;
    logic perm_n_s;
    logic thermal_shutdown_limit_s;
    logic ocp_s;
    logic therm_ok_s;
    logic bootstrap_node_s;
    logic syn_s;
    logic near_s;
    logic cmp_s;
    logic settle_done;
    logic settle_tmr_done;
    logic ph_load;
    logic [`CHG_PH_W-1:0] ph_val;
    logic ph_done;
    logic tick;
    logic run;
    logic refresh_req;

    chg_sync #(
        .W(`CHG_SYNC_N)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .d_i({adapter_detect_input_i, gate_drive_ldo_ok_i,
              aux_5v_ldo_ok_i, charge_permit_pin_n_i,
              thermal_shutdown_limit_i, overcurrent_i,
              thermistor_sense_ok_i, bootstrap_low_i,
              sync_threshold_above_i, adapter_near_pack_i,
              error_amp_above_ramp_i}),
        .q_o(sync_q)
    );

    assign {det_s, ldo_s, aux_s, perm_n_s, thermal_shutdown_limit_s, ocp_s,
            therm_ok_s, bootstrap_node_s, syn_s, near_s, cmp_s} = sync_q;

    // held loaded while no adapter, so each new detection restarts it
    chg_timer #(
        .CW(`CHG_SETTLE_W)
    ) u_settle (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .load_i(!det_s),
        .load_val_i(`CHG_SETTLE_W'(SETTLE_CYC - 1)),
        .done_o(settle_tmr_done)
    );

    assign settle_done = det_s && settle_tmr_done;

    chg_timer #(
        .CW(`CHG_PH_W)
    ) u_phase (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .load_i(ph_load),
        .load_val_i(ph_val),
        .done_o(ph_done)
    );

    assign tick = (st.per == '0);
    assign run = st.en;
    assign refresh_req = (st.bootstrap_node_cnt > `CHG_BOOTSTRAP_NODE_CYC);

    always_comb
    begin
        nxt = st;
        ph_load = 1'b0;
        ph_val = `CHG_PH_W'(`CHG_DEAD_CYC - 1);
        if (reg_wr_i && reg_addr_i == `CHG_MODE_ADDR)
            nxt.mode = reg_wdata_i;
        nxt.rdata = '0;
        if (reg_addr_i == `CHG_MODE_ADDR)
            nxt.rdata = st.mode;
        else if (reg_addr_i == `CHG_STAT_ADDR)
        begin
            nxt.rdata[`CHG_UNRDY_BIT] = st.unready;
            nxt.rdata[`CHG_OFF_BIT] = st.off;
        end
        nxt.unready = !det_s || !settle_done || !ldo_s || !aux_s;
        nxt.off = perm_n_s || st.mode[`CHG_STOP_BIT] || thermal_shutdown_limit_s
            || ocp_s || !therm_ok_s;
        nxt.en = !nxt.unready && !nxt.off;
        nxt.bypass = det_s && settle_done && !near_s;
        if (tick)
        begin
            if (st.mode[`CHG_FS_BIT])
                nxt.per = `CHG_PER_W'(`CHG_PER_HI - 1);
            else
                nxt.per = `CHG_PER_W'(`CHG_PER_LO - 1);
        end
        else
            nxt.per = st.per - 1'b1;
        // count switching cycles of high-side conduction with low bootstrap
        if (!bootstrap_node_s)
            nxt.bootstrap_node_cnt = '0;
        else if (st.fsm == ST_HS && tick && !refresh_req)
            nxt.bootstrap_node_cnt = st.bootstrap_node_cnt + 1'b1;
        unique case (st.fsm)
            ST_OFF:
            begin
                if (tick && run && cmp_s)
                    nxt.fsm = ST_HS;
            end
            ST_HS:
            begin
                // a full request keeps the high side on across periods until a bootstrap refresh is due
                if (!run || !cmp_s || refresh_req)
                begin
                    nxt.fsm = ST_DT1;
                    ph_load = 1'b1;
                end
            end
            ST_DT1:
            begin
                if (ph_done)
                begin
                    if (!run)
                        nxt.fsm = ST_OFF;
                    else
                    begin
                        nxt.fsm = ST_LS;
                        nxt.pulse = !syn_s || refresh_req;
                        if (nxt.pulse)
                        begin
                            ph_load = 1'b1;
                            ph_val = `CHG_PH_W'(`CHG_PULSE_CYC - 1);
                        end
                        if (refresh_req)
                            nxt.bootstrap_node_cnt = '0;
                    end
                end
            end
            ST_LS:
            begin
                if (st.pulse)
                begin
                    if (ph_done)
                        nxt.fsm = ST_OFF;
                end
                else if (tick || !run)
                begin
                    nxt.fsm = ST_DT2;
                    ph_load = 1'b1;
                end
            end
            ST_DT2:
            begin
                if (ph_done)
                begin
                    if (run && cmp_s)
                        nxt.fsm = ST_HS;
                    else
                        nxt.fsm = ST_OFF;
                end
            end
        endcase
        nxt.hs = (nxt.fsm == ST_HS);
        nxt.ls = (nxt.fsm == ST_LS);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
            st <= ST_RST;
        else
            st <= nxt;
    end

    assign reg_rdata_o = st.rdata;
    assign hs_gate_o = st.hs;
    assign ls_gate_o = st.ls;
    assign bypass_on_o = st.bypass;
    assign charge_unready_flag_o = st.unready;
    assign charger_off_o = st.off;
    assign charge_enable_o = st.en;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_ls_pulse;
        ls_gate_o [*2] ##1 !ls_gate_o;
    endsequence

    sequence s_dead_then_ls;
        !hs_gate_o ##[1:2] ls_gate_o;
    endsequence

    settle_restart_a: assert property (
        !det_s |=> !settle_done && charge_unready_flag_o)
        else $error("settle delay not restarted on detect loss");

    stop_reset_a: assert property (
        !$past(rstn_i) |-> st.mode[`CHG_STOP_BIT])
        else $error("stop bit not high after reset");

    rate_reset_a: assert property (
        !$past(rstn_i) |-> !st.mode[`CHG_FS_BIT])
        else $error("rate select not low after reset");

    unready_flag_a: assert property (
        !ldo_s || !aux_s |=> charge_unready_flag_o)
        else $error("unready flag low with a supply down");

    no_charge_unready_a: assert property (
        charge_unready_flag_o [*2] |-> !hs_gate_o && !charge_enable_o)
        else $error("high side on while not ready");

    off_flag_a: assert property (
        perm_n_s || thermal_shutdown_limit_s || ocp_s |=> charger_off_o)
        else $error("off flag low with a blocking condition");

    refresh_seq_a: assert property (
        st.fsm == ST_HS && refresh_req && run |=> s_dead_then_ls)
        else $error("bootstrap refresh not issued");

    rate_period_a: assert property (
        tick |=> st.per == ($past(st.mode[`CHG_FS_BIT])
            ? `CHG_PER_W'(`CHG_PER_HI - 1)
            : `CHG_PER_W'(`CHG_PER_LO - 1)))
        else $error("switching period does not follow rate select");

    gate_overlap_a: assert property (
        !(hs_gate_o && ls_gate_o) && !($rose(ls_gate_o) && $past(hs_gate_o))
        && !($rose(hs_gate_o) && $past(ls_gate_o)))
        else $error("gates overlap or lack dead time");

    recharge_pulse_a: assert property (
        $rose(ls_gate_o) && st.pulse |-> s_ls_pulse)
        else $error("recharge pulse width wrong");

    zero_duty_a: assert property (
        tick && !cmp_s && st.fsm == ST_OFF |=> !hs_gate_o && !ls_gate_o)
        else $error("gate driven in zero-duty cycle");

    bypass_near_a: assert property (
        near_s |=> !bypass_on_o)
        else $error("bypass on while adapter near pack");

endmodule // chg_ctrl

`default_nettype wire

// ==== tb/chg_bst_model.sv ====
// Purpose: bootstrap capacitor model at the gate driver side
// Assumes: high side held on drains the capacitor, a low-side pulse refills it
// Notes: droop is only shown while leak_en_i is high
`timescale 1ns/100ps
`default_nettype none

module chg_bst_model #(
    parameter int LEAK_CYC = 30
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic hs_gate_i,
    input wire logic ls_gate_i,
    input wire logic leak_en_i,
    output logic bootstrap_low_o
);
    int on_cnt;
    // switch node pulled down by the low side recharges the capacitor
    always_ff @(posedge ref_clk_i)
        if (!rstn_i || ls_gate_i)
            on_cnt <= 0;
        else if (hs_gate_i && on_cnt < 1000)
            on_cnt <= on_cnt + 1;
    assign bootstrap_low_o = leak_en_i && on_cnt >= LEAK_CYC;
endmodule // chg_bst_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for chg_ctrl
// Assumes: settle count shortened to 20 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none
`include "chg_params.svh"

module tb_top;
    logic clk = 0, rstn = 0, wr = 0, adp = 0, near = 0, cmp = 0, syn = 0, leak = 0, ovl = 0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wd = 16'h0000, rd;
    logic [3:0] flt = 4'h0;
    logic [1:0] sup = 2'h3;
    logic hs, ls, byp, unr, off, en, bst;
    int fail_count = 0, n_checks = 0, cyc = 0;
    always #25 clk = ~clk;
    chg_ctrl #(.SETTLE_CYC(20)) dut (
        .ref_clk_i(clk), .rstn_i(rstn), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rd), .adapter_detect_input_i(adp), .gate_drive_ldo_ok_i(sup[0]),
        .aux_5v_ldo_ok_i(sup[1]), .charge_permit_pin_n_i(flt[0]), .thermal_shutdown_limit_i(flt[1]),
        .overcurrent_i(flt[2]), .thermistor_sense_ok_i(!flt[3]), .bootstrap_low_i(bst),
        .sync_threshold_above_i(syn), .adapter_near_pack_i(near), .error_amp_above_ramp_i(cmp),
        .hs_gate_o(hs), .ls_gate_o(ls), .bypass_on_o(byp), .charge_unready_flag_o(unr),
        .charger_off_o(off), .charge_enable_o(en));
    chg_bst_model bst_m (.ref_clk_i(clk), .rstn_i(rstn), .hs_gate_i(hs), .ls_gate_i(ls),
        .leak_en_i(leak), .bootstrap_low_o(bst));

    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        addr = a;
        wd = d;
        wr = 1;
        tk(1);
        wr = 0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [15:0] d);
        addr = a;
        tk(1);
        d = rd;
    endtask
    // w selects the watched output: 0 high-side gate, 1 unready flag
    task automatic wt(input int w, input logic v, output int n);
        n = 0;
        while (((w == 0) ? hs : unr) !== v && n < 400)
        begin
            tk(1);
            n++;
        end
        chk(n < 400, 1);
    endtask

    task automatic t_reset;
        logic [15:0] v;
        rreg(`CHG_MODE_ADDR, v);
        chk(v, 16'h0001);
        rreg(`CHG_STAT_ADDR, v);
        chk(v, 16'h0003);
        chk({hs, ls, en}, 3'h0);
        $display("test reset done");
    endtask
    task automatic t_settle;
        int n;
        wreg(`CHG_MODE_ADDR, 16'h0000);
        adp = 1;
        tk(10);
        chk(unr, 1);
        adp = 0;
        tk(3);
        adp = 1;
        tk(15);
        chk(unr, 1);
        wt(1, 0, n);
        chk(n > 2, 1);
        tk(1);
        chk({off, en}, 2'h1);
        $display("test settle done");
    endtask
    task automatic t_flags;
        for (int k = 0; k < 6; k++)
        begin
            if (k < 4)
                flt = 4'h1 << k;
            else
                sup = (k == 4) ? 2'h2 : 2'h1;
            tk(4);
            chk(en, 0);
            chk({unr, off}, (k < 4) ? 2'h1 : 2'h2);
            flt = 4'h0;
            sup = 2'h3;
            tk(4);
            chk({unr, off, en}, 3'h1);
        end
        wreg(`CHG_MODE_ADDR, 16'h0001);
        tk(4);
        chk({off, en}, 2'h2);
        wreg(`CHG_MODE_ADDR, 16'h0000);
        tk(4);
        chk(en, 1);
        $display("test flags done");
    endtask
    task automatic t_regs;
        logic [15:0] v;
        wreg(`CHG_STAT_ADDR, 16'hffff);
        rreg(`CHG_STAT_ADDR, v);
        chk(v, 16'h0000);
        rreg(8'h55, v);
        chk(v, 16'h0000);
        wreg(`CHG_MODE_ADDR, 16'h0020);
        rreg(`CHG_MODE_ADDR, v);
        chk(v, 16'h0020);
        $display("test regs done");
    endtask
    task automatic t_gate(input logic s, input int per);
        int n1, n2;
        cmp = 0;
        tk(150);
        syn = s;
        cmp = 1;
        wt(0, 1, n1);
        cmp = 0;
        wt(0, 0, n1);
        chk(ls, 0);
        tk(1);
        chk(ls, 1);
        tk(1);
        chk(ls, 1);
        tk(1);
        chk(ls, s);
        cmp = 1;
        wt(0, 1, n2);
        if (!s)
            chk(n1 + n2 + 3, per);
        $display("test gate done");
    endtask
    task automatic t_zero;
        logic bad;
        bad = 0;
        syn = 0;
        cmp = 0;
        tk(140);
        repeat (140)
        begin
            tk(1);
            bad |= hs | ls;
        end
        chk(bad, 0);
        $display("test zero duty done");
    endtask
    task automatic t_boot;
        int n, first, cnt;
        logic full, prev;
        cmp = 1;
        wt(0, 1, n);
        full = 1;
        repeat (200)
        begin
            tk(1);
            full &= hs & !ls;
        end
        chk(full, 1);
        leak = 1;
        cnt = 0;
        prev = 0;
        first = 0;
        for (int i = 1; i < 900; i++)
        begin
            tk(1);
            if (ls && !prev)
            begin
                if (cnt == 0)
                    first = i;
                cnt++;
            end
            prev = ls;
        end
        chk(first >= 3 * `CHG_PER_LO && first <= 4 * `CHG_PER_LO + 4, 1);
        chk(cnt >= 2, 1);
        leak = 0;
        $display("test bootstrap done");
    endtask
    task automatic t_byp;
        chk(byp, 1);
        near = 1;
        tk(4);
        chk(byp, 0);
        near = 0;
        tk(4);
        chk(byp, 1);
        $display("test bypass done");
    endtask

    always @(posedge clk)
    begin
        if (hs === 1'b1 && ls === 1'b1)
            ovl <= 1;
        cyc++;
        if (cyc == 10000)
        begin
            fail_count++;
            complete_run();
        end
    end
    initial
    begin
        tk(5);
        rstn = 1;
        t_reset();
        t_settle();
        t_flags();
        t_regs();
        t_gate(0, `CHG_PER_HI);
        t_gate(1, `CHG_PER_HI);
        wreg(`CHG_MODE_ADDR, 16'h0000);
        t_gate(0, `CHG_PER_LO);
        t_zero();
        t_boot();
        t_byp();
        chk(ovl, 0);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
